/* File: logic/icq_cmd_decode.sv */
`timescale 1ns/1ps
// Purpose: field decode and legality check of one command entry
// Assumes: inputs held stable while the entry is examined
// Notes: combinational only

module icq_cmd_decode import icq_pkg::*; (
  icq_dec_if.dec d
);

  // ***************************************
  // Field extraction
  // ***************************************
  wire [7:0] opc = d.cmd[7:0];
  wire sec_sel = d.cmd[F_SEC_SEL];
  wire [STRIDE_W-1:0] stride = d.cmd[F_STRIDE_LO +: STRIDE_W];
  assign d.is_cfg = (opc == OPC_PF_CFG);
  assign d.is_addr = (opc == OPC_PF_ADDR);
  assign d.is_bar = (opc == OPC_BARRIER);
  assign d.sub_valid = d.cmd[F_SUB_VALID];
  assign d.ssid = d.cmd[F_SSID_LO +: SSID_W];
  assign d.sid = d.cmd[F_SID_LO +: SID_W];
  assign d.size = d.cmd[F_SIZE_LO +: SIZE_W];
  assign d.ns = d.cmd[F_NS];
  // Low page bits never come from the entry
  assign d.addr = {d.cmd[CMD_W-1:F_ADDR_LO], {VA_LSB{1'b0}}};

  // Secure selector only counts on a secure queue
  assign d.sec = d.secure_q & d.flag_a & sec_sel;

  // ***************************************
  // Reserved fields and legality
  // ***************************************
  wire ns_rsvd = ~d.secure_q | ~sec_sel | ~d.s2_sec;
  wire rsvd_cfg = (|d.cmd[9:8]) | (|d.cmd[CMD_W-1:F_NS]);
  // Stride is reserved in this revision; ignored unless checking is on
  wire rsvd_addr = (|d.cmd[9:8]) | d.cmd[F_RSV_A] | (|stride) | (ns_rsvd & d.ns);
  wire rsvd_bad = d.chk_rsvd & ((d.is_cfg & rsvd_cfg) | (d.is_addr & rsvd_addr));
  wire sec_sel_bad = ~d.secure_q & sec_sel & (d.is_cfg | d.is_addr);
  assign d.illegal = ~(d.is_cfg | d.is_addr | d.is_bar) | rsvd_bad | sec_sel_bad;

  // ***************************************
  // Range of stream and substream indices
  // ***************************************
  wire [5:0] w = d.sec ? d.s_sid_w : d.sid_w;
  wire [63:0] sid_hi = {32'h0, d.sid} >> w;
  wire [63:0] ssid_hi = {44'h0, d.ssid} >> d.ssid_w;
  // Stream index, or a supplied substream index, can be out of range
  assign d.oor = (|sid_hi) | (d.sub_valid & (d.ssid_w != 5'h0) & (|ssid_hi));

endmodule

/* File: logic/icq_cmd_queue_prefetch.sv */
`timescale 1ns/1ps
// Purpose: consumes the command queue and runs prefetch commands
// Assumes: memory, config cache and walker answer on clk
// Notes: registers reached over AHB-Lite, zero wait states

module icq_cmd_queue_prefetch import icq_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  output logic mem_req,
  output logic [63:0] mem_addr,
  input wire logic mem_ack,
  input wire logic mem_abort,
  input wire logic [CMD_W-1:0] mem_rdata,
  output logic cfg_req,
  input wire logic cfg_ack,
  input wire logic cfg_ste_valid,
  input wire logic cfg_s1_en,
  input wire logic cfg_s2_en,
  input wire logic cfg_s1_bypass,
  input wire logic [4:0] cfg_cd_max,
  input wire logic cfg_cd_fetched,
  input wire logic [6:0] cfg_vas,
  input wire logic [6:0] cfg_ias,
  output logic [SID_W-1:0] tgt_sid,
  output logic tgt_sec,
  output logic [SSID_W-1:0] tgt_ssid,
  output logic tgt_sub_valid,
  output logic acc_flag_req,
  output logic walk_req,
  output logic [63:0] walk_addr,
  output logic walk_ns,
  output logic walk_ns_use,
  input wire logic walk_ack,
  output logic barrier_done
);

  typedef enum logic [2:0] {S_IDLE, S_FETCH, S_DEC, S_CFG, S_WALK, S_CONS, S_ERR} icq_state_t;

  // ***************************************
  // Register file and bus state
  // ***************************************
  icq_state_t st_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [39:0] qbase_q;
  logic [3:0] qlog2_q;
  logic [QIDX_W:0] prod_q;
  logic [QIDX_W:0] cons_q;
  logic [1:0] err_q;
  logic [5:0] sid_w_q;
  logic [5:0] s_sid_w_q;
  logic [4:0] ssid_w_q;
  logic [15:0] wlim_q;
  logic wr_pend_q;
  logic [7:0] wr_addr_q;
  logic [CMD_W-1:0] cmd_q;
  logic is_addr_q;
  logic s1_q;
  logic s2_q;
  logic [6:0] vas_q;
  logic [6:0] ias_q;
  logic [SIZE_W-1:0] size_q;
  logic [31:0] walk_n_q;
  logic ns_q;

  icq_dec_if d ();

  icq_cmd_decode u_dec (
    .d(d)
  );

  assign d.cmd = cmd_q;
  assign d.secure_q = ctrl_q[C_SECURE_Q];
  assign d.flag_a = ctrl_q[C_FLAG_A];
  assign d.chk_rsvd = ctrl_q[C_CHK_RSVD];
  assign d.s2_sec = ctrl_q[C_S2_SEC];
  assign d.sid_w = sid_w_q;
  assign d.s_sid_w = s_sid_w_q;
  assign d.ssid_w = ssid_w_q;

  // ***************************************
  // AHB-Lite slave
  // ***************************************
  // Zero-wait slave: address phase taken whenever the bus is ready
  wire a_ok = hsel & htrans[1] & hready;
  wire we_any = wr_pend_q;
  wire we_ctrl = we_any & (wr_addr_q == REG_CTRL);
  wire we_qlo = we_any & (wr_addr_q == REG_QBASE_LO);
  wire we_qhi = we_any & (wr_addr_q == REG_QBASE_HI);
  wire we_qlog2 = we_any & (wr_addr_q == REG_QLOG2);
  wire we_prod = we_any & (wr_addr_q == REG_PROD);
  wire we_err = we_any & (wr_addr_q == REG_ERR);
  wire we_widths = we_any & (wr_addr_q == REG_WIDTHS);
  wire we_wlim = we_any & (wr_addr_q == REG_WLIMIT);
  wire [7:0] ra = haddr[7:0];
  // Unmapped words read as zero and ignore writes
  wire [31:0] rd_val =
    (ra == REG_CTRL) ? {25'h0, ctrl_q} :
    (ra == REG_QBASE_LO) ? {qbase_q[19:0], 12'h0} :
    (ra == REG_QBASE_HI) ? {12'h0, qbase_q[39:20]} :
    (ra == REG_QLOG2) ? {28'h0, qlog2_q} :
    (ra == REG_PROD) ? {23'h0, prod_q} :
    (ra == REG_CONS) ? {(st_q == S_ERR), 2'h0, 5'h0, st_q, 5'h0, 7'h0, cons_q} :
    (ra == REG_ERR) ? {30'h0, err_q} :
    (ra == REG_WIDTHS) ? {11'h0, ssid_w_q, 2'h0, s_sid_w_q, 2'h0, sid_w_q} :
    (ra == REG_WLIMIT) ? {16'h0, wlim_q} : 32'h0;

  // Address phase capture and read data
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 8'h0;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_q <= a_ok & hwrite;
      if (a_ok) begin
        wr_addr_q <= ra;
      end
      if (a_ok & ~hwrite) begin
        hrdata <= rd_val;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl_q <= CTRL_RST;
      qbase_q <= 40'h0;
      qlog2_q <= QLOG2_RST;
      prod_q <= '0;
      sid_w_q <= SID_W_RST;
      s_sid_w_q <= SID_W_RST;
      ssid_w_q <= SSID_W_RST;
      wlim_q <= WLIMIT_RST;
    end else begin
      if (we_ctrl) ctrl_q <= hwdata[CTRL_W-1:0];
      if (we_qlo) qbase_q[19:0] <= hwdata[31:12];
      if (we_qhi) qbase_q[39:20] <= hwdata[19:0];
      if (we_qlog2) qlog2_q <= (hwdata[3:0] > 4'h8) ? 4'h8 : hwdata[3:0];
      if (we_prod) prod_q <= hwdata[QIDX_W:0];
      if (we_widths) begin
        sid_w_q <= (hwdata[5:0] > 6'd32) ? 6'd32 : hwdata[5:0];
        s_sid_w_q <= (hwdata[13:8] > 6'd32) ? 6'd32 : hwdata[13:8];
        ssid_w_q <= hwdata[20:16];
      end
      if (we_wlim) wlim_q <= hwdata[15:0];
    end
  end

  // ***************************************
  // Queue indices and fetch address
  // ***************************************
  // Index wraps at 2^qlog2 entries; top bit is the wrap flag
  wire [QIDX_W-1:0] qmask = QIDX_W'((9'h1 << qlog2_q) - 9'h1);
  wire [QIDX_W-1:0] cons_idx = cons_q[QIDX_W-1:0] & qmask;
  wire cons_last = (cons_idx == qmask);
  wire [QIDX_W:0] cons_nx = cons_last ? {~cons_q[QIDX_W], {QIDX_W{1'b0}}} : cons_q + 1'b1;
  wire q_empty = ((prod_q[QIDX_W-1:0] & qmask) == cons_idx) & (prod_q[QIDX_W] == cons_q[QIDX_W]);
  // Base is a physical page address, upper and lower bits zero
  wire [63:0] qbase_pa = {12'h0, qbase_q, 12'h0};
  wire [63:0] slot_addr = qbase_pa + ({56'h0, cons_idx} << ENTRY_SHIFT);

  // ***************************************
  // Prefetch decisions
  // ***************************************
  wire xlate_en = ctrl_q[C_XLATE_EN];
  // With a zero substream width (ssid_w_q) the flag acts as zero
  wire sub_valid_eff = d.sub_valid & (ssid_w_q != 5'h0);
  wire sub_valid_cd = tgt_sub_valid & (cfg_cd_max != 5'h0);
  // Out-of-range or disabled prefetch: consume with no effect
  wire pf_skip = ~xlate_en | d.oor;
  wire [63:0] sext = $signed(walk_addr) >>> (vas_q - 7'd1);
  wire oor_s1 = s1_q & ~((sext == 64'h0) | (sext == {64{1'b1}}));
  wire oor_s2 = s2_q & ((walk_addr >> ias_q) != 64'h0);
  wire addr_oor = oor_s1 | oor_s2;
  wire [32:0] walk_tot = 33'h1 << size_q;
  wire [32:0] walk_nx = {1'b0, walk_n_q} + 33'h1;
  // A nonzero cap keeps every address prefetch bounded in time
  wire walk_end = (walk_nx == walk_tot) | (walk_nx == {17'h0, wlim_q});
  wire ns_use_d = tgt_sec & cfg_s2_en & (~cfg_s1_en | cfg_s1_bypass);

  // ***************************************
  // Command sequencer
  // ***************************************
  // One command at a time, so a barrier finds all earlier work finished
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      cons_q <= '0;
      err_q <= ERR_NONE;
      cmd_q <= '0;
      mem_req <= 1'b0;
      mem_addr <= 64'h0;
      barrier_done <= 1'b0;
    end else begin
      barrier_done <= 1'b0;
      case (st_q)
        S_IDLE: begin
          if (ctrl_q[C_QEN] & ~q_empty) begin
            mem_req <= 1'b1;
            mem_addr <= slot_addr;
            st_q <= S_FETCH;
          end
        end
        S_FETCH: begin
          if (mem_ack) begin
            mem_req <= 1'b0;
            cmd_q <= mem_rdata;
            if (mem_abort) begin
              err_q <= ERR_ABT;
              st_q <= S_ERR;
            end else begin
              st_q <= S_DEC;
            end
          end
        end
        S_DEC: begin
          if (d.illegal) begin
            err_q <= ERR_ILL;
            st_q <= S_ERR;
          end else if (d.is_bar) begin
            barrier_done <= 1'b1;
            st_q <= S_CONS;
          end else if (pf_skip) begin
            st_q <= S_CONS;
          end else begin
            st_q <= S_CFG;
          end
        end
        S_CFG: begin
          if (cfg_ack) begin
            st_q <= (is_addr_q & cfg_ste_valid) ? S_WALK : S_CONS;
          end
        end
        S_WALK: begin
          if (walk_end & ((~walk_req & addr_oor) | (walk_req & walk_ack))) begin
            st_q <= S_CONS;
          end
        end
        S_CONS: begin
          cons_q <= cons_nx;
          st_q <= S_IDLE;
        end
        S_ERR: begin
          // Read index stays on the failing entry until software clears
          if (we_err) begin
            err_q <= ERR_NONE;
            st_q <= S_IDLE;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  // ***************************************
  // Configuration prefetch request
  // ***************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      cfg_req <= 1'b0;
      tgt_sid <= '0;
      tgt_sec <= 1'b0;
      tgt_ssid <= '0;
      tgt_sub_valid <= 1'b0;
      is_addr_q <= 1'b0;
      size_q <= '0;
      ns_q <= 1'b0;
      acc_flag_req <= 1'b0;
    end else begin
      acc_flag_req <= 1'b0;
      if ((st_q == S_DEC) & ~d.illegal & ~d.is_bar & ~pf_skip) begin
        cfg_req <= 1'b1;
        tgt_sid <= d.sid;
        tgt_sec <= d.sec;
        tgt_ssid <= sub_valid_eff ? d.ssid : {SSID_W{1'b0}};
        tgt_sub_valid <= sub_valid_eff;
        is_addr_q <= d.is_addr;
        size_q <= d.size;
        ns_q <= d.ns;
      end else if ((st_q == S_CFG) & cfg_ack) begin
        cfg_req <= 1'b0;
        tgt_sub_valid <= sub_valid_cd;
        // Access flag in the stage-2 descriptor used for the fetch
        acc_flag_req <= cfg_ste_valid & cfg_s1_en & cfg_s2_en & cfg_cd_fetched & ctrl_q[C_HW_FLAG_UPD];
      end
    end
  end

  // ***************************************
  // Translation walk loop
  // ***************************************
  // Faults reported by the walker are simply dropped here
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      walk_req <= 1'b0;
      walk_addr <= 64'h0;
      walk_n_q <= 32'h0;
      walk_ns <= 1'b0;
      walk_ns_use <= 1'b0;
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      vas_q <= 7'h0;
      ias_q <= 7'h0;
    end else if ((st_q == S_CFG) & cfg_ack) begin
      walk_addr <= d.addr;
      walk_n_q <= 32'h0;
      s1_q <= cfg_s1_en & ~cfg_s1_bypass;
      s2_q <= cfg_s2_en;
      vas_q <= cfg_vas;
      ias_q <= cfg_ias;
      walk_ns_use <= ns_use_d;
      walk_ns <= ns_use_d & ns_q;
    end else if (st_q == S_WALK) begin
      if (~walk_req & ~addr_oor) begin
        walk_req <= 1'b1;
      end else if ((~walk_req & addr_oor) | walk_ack) begin
        // Skipped or answered page: step one page on
        walk_req <= 1'b0;
        walk_n_q <= walk_nx[31:0];
        walk_addr <= walk_addr + (64'h1 << VA_LSB);
      end
    end
  end

endmodule

/* File: logic/icq_dec_if.sv */
`timescale 1ns/1ps
// Purpose: carries a queued command and its decoded fields
// Assumes: decoder is purely combinational
// Notes: one modport per side

interface icq_dec_if;
  import icq_pkg::*;
  logic [CMD_W-1:0] cmd;
  logic secure_q;
  logic flag_a;
  logic chk_rsvd;
  logic s2_sec;
  logic [5:0] sid_w;
  logic [5:0] s_sid_w;
  logic [4:0] ssid_w;
  logic is_cfg;
  logic is_addr;
  logic is_bar;
  logic illegal;
  logic oor;
  logic sub_valid;
  logic sec;
  logic ns;
  logic [SSID_W-1:0] ssid;
  logic [SID_W-1:0] sid;
  logic [SIZE_W-1:0] size;
  logic [63:0] addr;
  modport dec (input cmd, secure_q, flag_a, chk_rsvd, s2_sec, sid_w, s_sid_w, ssid_w,
               output is_cfg, is_addr, is_bar, illegal, oor, sub_valid, sec, ns, ssid, sid, size, addr);
  modport host (output cmd, secure_q, flag_a, chk_rsvd, s2_sec, sid_w, s_sid_w, ssid_w,
               input is_cfg, is_addr, is_bar, illegal, oor, sub_valid, sec, ns, ssid, sid, size, addr);
endinterface

/* File: logic/icq_pkg.sv */
// Purpose: shared constants for the command queue and prefetch engine
// Assumes: 128-bit command entries, 32-bit register bus
// Notes: field positions describe the little-endian entry image

package icq_pkg;

  // ***************************************
  // Command entry layout
  // ***************************************
  localparam int CMD_W = 128;
  localparam int ENTRY_SHIFT = 4;
  localparam logic [7:0] OPC_PF_CFG = 8'h01;
  localparam logic [7:0] OPC_PF_ADDR = 8'h02;
  localparam logic [7:0] OPC_BARRIER = 8'h46;
  localparam int F_SUB_VALID = 10;
  localparam int F_SEC_SEL = 11;
  localparam int F_SSID_LO = 12;
  localparam int SSID_W = 20;
  localparam int F_SID_LO = 32;
  localparam int SID_W = 32;
  localparam int F_NS = 64;
  localparam int F_SIZE_LO = 65;
  localparam int SIZE_W = 5;
  localparam int F_STRIDE_LO = 70;
  localparam int STRIDE_W = 5;
  localparam int F_RSV_A = 75;
  localparam int F_ADDR_LO = 76;
  localparam int VA_LSB = 12;
  localparam int PA_MSB = 51;

  // ***************************************
  // Register offsets and reset values
  // ***************************************
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_QBASE_LO = 8'h04;
  localparam logic [7:0] REG_QBASE_HI = 8'h08;
  localparam logic [7:0] REG_QLOG2 = 8'h0c;
  localparam logic [7:0] REG_PROD = 8'h10;
  localparam logic [7:0] REG_CONS = 8'h14;
  localparam logic [7:0] REG_ERR = 8'h18;
  localparam logic [7:0] REG_WIDTHS = 8'h1c;
  localparam logic [7:0] REG_WLIMIT = 8'h20;
  localparam int C_QEN = 0;
  localparam int C_XLATE_EN = 1;
  localparam int C_FLAG_A = 2;
  localparam int C_SECURE_Q = 3;
  localparam int C_CHK_RSVD = 4;
  localparam int C_HW_FLAG_UPD = 5;
  localparam int C_S2_SEC = 6;
  localparam int CTRL_W = 7;
  localparam logic [CTRL_W-1:0] CTRL_RST = 7'h00;
  localparam int QIDX_W = 8;
  localparam logic [3:0] QLOG2_RST = 4'h4;
  localparam logic [15:0] WLIMIT_RST = 16'h0100;
  localparam logic [5:0] SID_W_RST = 6'h10;
  localparam logic [4:0] SSID_W_RST = 5'h00;

  // ***************************************
  // Error codes
  // ***************************************
  localparam logic [1:0] ERR_NONE = 2'h0;
  localparam logic [1:0] ERR_ILL = 2'h1;
  localparam logic [1:0] ERR_ABT = 2'h2;

endpackage

/* File: verification/icq_chk.sv */
`timescale 1ns/1ps
// Purpose: port-level checks on the command queue and prefetch block
// Assumes: one clock domain, asynchronous active-low reset
// Notes: bound to every instance of the top module

module icq_chk (
  input wire logic clk,
  input wire logic nrst,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [63:0] mem_addr,
  input wire logic cfg_req,
  input wire logic cfg_ack,
  input wire logic walk_req,
  input wire logic walk_ack,
  input wire logic [63:0] walk_addr,
  input wire logic walk_ns_use,
  input wire logic tgt_sec,
  input wire logic acc_flag_req,
  input wire logic barrier_done
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // ****************
  // Request handshakes
  // ****************
  // A fetch that moves early would read a slot the producer may reuse
  a_fetch_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
    else $error("fetch dropped or moved before ack");
  a_entry_align: assert property (mem_req |-> mem_addr[3:0] == 4'h0 && mem_addr[63:52] == 12'h0)
    else $error("fetch address not on an entry");
  a_one_active: assert property (mem_req |-> !walk_req && !cfg_req)
    else $error("fetch overlaps execution");
  a_walk_page: assert property (walk_req |-> walk_addr[11:0] == 12'h0)
    else $error("walk address has low bits set");
  a_walk_hold: assert property (walk_req && !walk_ack |=> walk_req && $stable(walk_addr))
    else $error("walk dropped or moved before ack");
  a_cfg_hold: assert property (cfg_req && !cfg_ack |=> cfg_req)
    else $error("config request dropped before ack");
  // Flag set only straight after a config answer, one cycle wide
  a_flag_cause: assert property (acc_flag_req |-> $past(cfg_ack) ##1 !acc_flag_req)
    else $error("access flag request without config answer");
  a_bar_quiet: assert property (barrier_done |-> !walk_req && !cfg_req ##1 !barrier_done)
    else $error("barrier done while work pending");
  a_ns_gate: assert property (walk_req && walk_ns_use |-> tgt_sec)
    else $error("attribute used for non-secure stream");

  // Main scenarios
  c_walk: cover property (walk_req && walk_ack);
  c_bar: cover property (barrier_done);
  c_acc_flag: cover property (acc_flag_req);
endmodule

bind icq_cmd_queue_prefetch icq_chk u_chk (.clk, .nrst, .mem_req, .mem_ack, .mem_addr, .cfg_req, .cfg_ack,
  .walk_req, .walk_ack, .walk_addr, .walk_ns_use, .tgt_sec, .acc_flag_req, .barrier_done);

/* File: verification/icq_cmd_queue_prefetch_test.sv */
`timescale 1ns/1ps
// Purpose: self-checking bench for the command queue and prefetch block
// Assumes: single AHB-Lite master, queue of sixteen entries at 0x1000
// Notes: random page addresses and sizes from a fixed seed

module icq_cmd_queue_prefetch_test;
  import icq_pkg::*;
  logic clk, nrst, hsel, hwrite, hreadyout, hresp, s2_on;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic mem_req, mem_ack, mem_abort, cfg_req, cfg_ack, cfg_ste_valid, cfg_s1_en, cfg_s2_en, cfg_s1_bypass;
  logic cfg_cd_fetched, tgt_sec, tgt_sub_valid, acc_flag_req, walk_req, walk_ns, walk_ns_use, walk_ack;
  logic barrier_done;
  logic [4:0] cfg_cd_max;
  logic [6:0] cfg_vas, cfg_ias;
  logic [63:0] mem_addr, walk_addr;
  logic [CMD_W-1:0] mem_rdata;
  logic [SID_W-1:0] tgt_sid;
  logic [SSID_W-1:0] tgt_ssid;
  int mismatches, n_checks, cyc, nbar, naf;
  logic [63:0] wq[$];
  logic [63:0] last_tgt;

  icq_cmd_queue_prefetch DUT (.clk, .nrst, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hrdata, .hresp, .mem_req, .mem_addr, .mem_ack, .mem_abort, .mem_rdata,
    .cfg_req, .cfg_ack, .cfg_ste_valid, .cfg_s1_en, .cfg_s2_en, .cfg_s1_bypass, .cfg_cd_max, .cfg_cd_fetched,
    .cfg_vas, .cfg_ias, .tgt_sid, .tgt_sec, .tgt_ssid, .tgt_sub_valid, .acc_flag_req, .walk_req, .walk_addr,
    .walk_ns, .walk_ns_use, .walk_ack, .barrier_done);
  icq_far_model MEM (.clk, .nrst, .s2_on, .mem_req, .mem_addr, .mem_ack, .mem_abort, .mem_rdata, .cfg_req,
    .cfg_ack, .cfg_ste_valid, .cfg_s1_en, .cfg_s2_en, .cfg_s1_bypass, .cfg_cd_max, .cfg_cd_fetched, .cfg_vas,
    .cfg_ias, .walk_req, .walk_ack);

  // ****************
  // Clock, monitors and hang guard
  // ****************
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // Walks and pulses are logged here, never inferred from consumption
  always @(posedge clk) begin
    cyc++;
    // Attribute folded into bit 0, which a page address never uses
    if (walk_req && walk_ack) wq.push_back(walk_addr | 64'(walk_ns));
    if (cfg_req && cfg_ack) last_tgt = 64'({tgt_ssid, tgt_sub_valid, tgt_sec, tgt_sid});
    if (barrier_done) nbar++;
    if (acc_flag_req) naf++;
    if (cyc == 20000) begin
      mismatches++;
      close_out();
    end
  end

  // ****************
  // Tasks and expectations
  // ****************
  // One single transfer; entered just after a rising edge
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    chk(64'(hresp), 64'h0);
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // Read until the masked value matches, bounded
  task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    ahb(1'b0, a, 32'h0);
    for (int i = 0; i < 200 && (rd & m) !== e; i++) ahb(1'b0, a, 32'h0);
  endtask

  task automatic run(input int s, input logic [CMD_W-1:0] e);
    MEM.q[s] = e;
    wq.delete();
    ahb(1'b1, REG_PROD, 32'(s + 1));
    poll(REG_CONS, 32'h1ff, 32'(s + 1));
  endtask

  function automatic logic [CMD_W-1:0] mk(input logic [7:0] op, input logic [3:0] fl, input logic [4:0] sz,
    input logic [4:0] st, input logic [63:0] va);
    logic [CMD_W-1:0] e;
    e = '0;
    e[7:0] = op;
    e[11:8] = fl;
    e[F_SID_LO +: 8] = 8'h21;
    e[F_SIZE_LO +: SIZE_W] = sz;
    e[F_STRIDE_LO +: STRIDE_W] = st;
    e[CMD_W-1:F_ADDR_LO] = va[63:VA_LSB];
    return e;
  endfunction

  function automatic logic [63:0] pg(input logic [63:0] va, input int n);
    return {va[63:VA_LSB], 12'h000} + (64'(n) << VA_LSB);
  endfunction

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // ****************
  // Main sequence
  // ****************
  initial begin
    logic [4:0] sz;
    logic [63:0] va;
    logic [7:0] eo [3];
    logic [3:0] ef [3];
    logic [31:0] ec [3];
    eo = '{8'h03, OPC_PF_CFG, OPC_PF_CFG};
    ef = '{4'h0, 4'h8, 4'h1};
    ec = '{32'h01, 32'h01, 32'h11};
    {nrst, hsel, hwrite, htrans, haddr, hwdata, s2_on} = '0;
    void'($urandom(21));
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    ahb(1'b0, REG_CTRL, 32'h0);
    chk(rd, 64'(CTRL_RST));
    ahb(1'b0, REG_QLOG2, 32'h0);
    chk(rd, 64'(QLOG2_RST));
    ahb(1'b0, REG_WLIMIT, 32'h0);
    chk(rd, 64'(WLIMIT_RST));
    ahb(1'b0, 8'h40, 32'h0);
    chk(rd, 64'h0);
    ahb(1'b1, REG_QBASE_LO, 32'h1000);
    ahb(1'b1, REG_CTRL, 32'h3);
    // Random spans; last one has a stride that must be ignored
    for (int k = 0; k < 4; k++) begin
      sz = 5'($urandom_range(2));
      va = {20'h0, $urandom(), 12'hfff};
      run(k, mk(OPC_PF_ADDR, 4'h0, sz, k == 3 ? 5'h2 : 5'h0, va));
      chk(rd & 32'h1ff, 64'(k + 1));
      chk(64'(wq.size()), 64'(1) << sz);
      foreach (wq[i]) chk(wq[i], pg(va, i));
    end
    ahb(1'b1, REG_WLIMIT, 32'h1);
    run(4, mk(OPC_PF_ADDR, 4'h0, 5'h2, 5'h0, va));
    chk(64'(wq.size()), 64'h1);
    run(5, mk(OPC_BARRIER, 4'h0, 5'h0, 5'h0, 64'h0));
    chk(64'(nbar), 64'h1);
    s2_on <= 1'b1;
    ahb(1'b1, REG_CTRL, 32'h23);
    run(6, mk(OPC_PF_CFG, 4'h0, 5'h0, 5'h0, 64'h0));
    chk(64'(naf), 64'h1);
    chk(last_tgt, 64'h21);
    s2_on <= 1'b0;
    ahb(1'b1, REG_CTRL, 32'h1);
    run(7, mk(OPC_PF_ADDR, 4'h0, 5'h1, 5'h0, va));
    chk(64'(wq.size()), 64'h0);
    // Bad opcode, selector on plain queue, reserved bit with checking on
    for (int j = 0; j < 3; j++) begin
      ahb(1'b1, REG_CTRL, ec[j]);
      MEM.q[8] = mk(eo[j], ef[j], 5'h0, 5'h0, 64'h0);
      ahb(1'b1, j == 0 ? REG_PROD : REG_ERR, 32'h9);
      poll(REG_ERR, 32'h3, 32'(ERR_ILL));
      chk(rd & 32'h3, 64'(ERR_ILL));
      ahb(1'b0, REG_CONS, 32'h0);
      chk(rd & 32'h800001ff, 64'h80000008);
    end
    ahb(1'b1, REG_CTRL, 32'h1);
    ahb(1'b1, REG_ERR, 32'h0);
    poll(REG_CONS, 32'h1ff, 32'h9);
    chk(rd & 32'h1ff, 64'h9);
    // Unreachable slot: abort code, index left on it
    MEM.q[9] = mk(8'hee, 4'h0, 5'h0, 5'h0, 64'h0);
    ahb(1'b1, REG_PROD, 32'ha);
    poll(REG_ERR, 32'h3, 32'(ERR_ABT));
    chk(rd & 32'h3, 64'(ERR_ABT));
    ahb(1'b0, REG_CONS, 32'h0);
    chk(rd & 32'h800001ff, 64'h80000009);
    close_out();
  end
endmodule

/* File: verification/icq_far_model.sv */
`timescale 1ns/1ps
// Purpose: queue memory, config cache and walker facing the block
// Assumes: queue base 0x1000, sixteen entries
// Notes: each answer comes after a random wait of zero or more cycles

module icq_far_model import icq_pkg::*; (
  input wire logic clk,
  input wire logic nrst,
  input wire logic s2_on,
  input wire logic mem_req,
  input wire logic [63:0] mem_addr,
  output logic mem_ack,
  output logic mem_abort,
  output logic [CMD_W-1:0] mem_rdata,
  input wire logic cfg_req,
  output logic cfg_ack,
  output logic cfg_ste_valid,
  output logic cfg_s1_en,
  output logic cfg_s2_en,
  output logic cfg_s1_bypass,
  output logic [4:0] cfg_cd_max,
  output logic cfg_cd_fetched,
  output logic [6:0] cfg_vas,
  output logic [6:0] cfg_ias,
  input wire logic walk_req,
  output logic walk_ack
);
  logic [CMD_W-1:0] q [16];
  logic [CMD_W-1:0] ent;

  // ****************
  // Queue slots and stream config
  // ****************
  // Data off the ack cycle is inverted so a stale sample shows up
  assign ent = q[mem_addr[7:4]];
  assign mem_rdata = mem_ack ? ent : ~ent;
  // Slots whose first byte is 0xee stand for an unreachable word
  assign mem_abort = mem_ack && ent[7:0] == 8'hee;
  assign cfg_ste_valid = 1'b1;
  assign cfg_s1_en = 1'b1;
  assign cfg_s2_en = s2_on;
  assign cfg_s1_bypass = 1'b0;
  assign cfg_cd_max = 5'h00;
  assign cfg_cd_fetched = s2_on;
  assign cfg_vas = 7'h30;
  assign cfg_ias = 7'h30;

  // One ack per request, after a coin-flip wait
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      cfg_ack <= 1'b0;
      walk_ack <= 1'b0;
    end else begin
      mem_ack <= mem_req && !mem_ack && $urandom_range(1) == 1;
      cfg_ack <= cfg_req && !cfg_ack && $urandom_range(1) == 1;
      walk_ack <= walk_req && !walk_ack && $urandom_range(1) == 1;
    end
  end
endmodule
